//--- include/iopw_regs.svh
// Register offsets, field positions, reset values and counts of the I/O port.
`ifndef IOPW_REGS_SVH
`define IOPW_REGS_SVH
`define IOPW_ADDR_PORT_A 8'h12
`define IOPW_ADDR_DIR_A 8'h13
`define IOPW_ADDR_PORT_B 8'h14
`define IOPW_ADDR_DIR_B 8'h15
`define IOPW_ADDR_FLAGS 8'h16
`define IOPW_ADDR_PORT_D 8'h18
`define IOPW_ADDR_DIR_D 8'h19
`define IOPW_WIDTH_A 8
`define IOPW_WIDTH_B 7
`define IOPW_WIDTH_D 5
`define IOPW_RST_A 8'hFF
`define IOPW_RST_B 7'h7F
`define IOPW_RST_D 5'h1F
`define IOPW_RST_FLAGS 8'h00
`define IOPW_FLAG_V0 0
`define IOPW_FLAG_V1 1
`define IOPW_FLAG_Z0 6
`define IOPW_FLAG_Z1 7
`define IOPW_Z_LO 4
`define IOPW_Z_HI 5
`define IOPW_V_LO 6
`define IOPW_V_HI 7
`define IOPW_SYNC_STAGES 2
`endif

//--- include/iopw_pkg.sv
// Types shared by the I/O port with wake-up.
package iopw_pkg;
    // Power state of the device as seen by the port.
    typedef enum logic [0:0] {
        IOPW_RUN = 1'b0,
        IOPW_DOWN = 1'b1
    } iopw_pwr_t;
endpackage

//--- verilog/iopw_top.sv
// I/O port block with direction control, latches and pin wake-up.
`timescale 1ns/10ps
`include "iopw_regs.svh"
// What this block does
// RL1: Twenty bidirectional lines over three mapped ports.
// RL2: Direction bit one means input, zero output.
// RL3: Output line reads return the data latch.
// RL4: Output latch holds until written again.
// RL5: Input reads sample pins, no latching.
// RL6: Reset sets data and direction to ones.
// RL7: Bit set and clear use read-modify-write.
// RL8: Pull-up only on input lines, by option.
// RL9: Halt stops clock until a wake event.
// RL10: Wake selectable per first-port line only.
// RL11: Falling edge on selected line wakes device.
// RL12: Z lines wake on both edges.
// RL13: V lines wake on both edges by option.
// RL14: V wake sets flag bits zero, one.
// RL15: Z wake sets flag bits six, seven.
// RL16: Reading Z port lines clears their flags.
// RL17: Shared timer line needs internal-clock timer mode.
// RL18: Software sets direction before port data.
// RL19: Direction writable bytewise or by single bit.
// RL20: Cleared flag reads set; event beats clear.
module iopw_top
    import iopw_pkg::*;
(
    input wire logic clk, // System clock, 200 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [7:0] mem_addr, // Data memory address.
    input wire logic mem_rd, // One-cycle read strobe at T2.
    input wire logic mem_wr, // One-cycle byte write strobe.
    input wire logic [7:0] mem_wdata, // Byte write data.
    input wire logic bit_op, // One-cycle single-bit instruction.
    input wire logic bit_set, // One sets the bit, zero clears it.
    input wire logic [2:0] bit_idx, // Bit addressed by bit_op.
    output logic [7:0] mem_rdata, // Read data, valid after mem_rd.
    output logic mem_rvalid, // Pulse marking mem_rdata valid.
    input wire logic halt, // One-cycle halt instruction pulse.
    output logic sys_clk_run, // High while the system clock runs.
    input wire logic [7:0] wake_sel, // Per-line wake option, port A.
    input wire logic v_wake_opt, // Both-edge wake option, V lines.
    input wire logic [19:0] pullup_opt, // Pull-up option per line.
    output logic [19:0] pullup_en, // Weak pull-up enables.
    input wire logic [7:0] pa_in, // Port A pin levels.
    output logic [7:0] pa_out, // Port A pin drive values.
    output logic [7:0] pa_oe, // Port A output enables.
    input wire logic [6:0] pb_in, // Port B pin levels.
    output logic [6:0] pb_out, // Port B pin drive values.
    output logic [6:0] pb_oe, // Port B output enables.
    input wire logic [4:0] pd_in, // Port D pin levels.
    output logic [4:0] pd_out, // Port D pin drive values.
    output logic [4:0] pd_oe // Port D output enables.
);

    // Output latches and direction registers of the three ports.
    logic [`IOPW_WIDTH_A-1:0] port_a_data;
    logic [`IOPW_WIDTH_A-1:0] port_a_direction;
    logic [`IOPW_WIDTH_B-1:0] port_b_data_lines;
    logic [`IOPW_WIDTH_B-1:0] port_b_direction_bits;
    logic [`IOPW_WIDTH_D-1:0] port_d_data_lines;
    logic [`IOPW_WIDTH_D-1:0] port_d_direction_bits;
    // Sticky wake-up flags, cleared by reading.
    logic [7:0] wake_edge_flags;
    // Power state.
    iopw_pwr_t pwr;

    // Two-stage synchronisers; stage one feeds only stage two.
    logic [19:0] pin_meta;
    logic [19:0] pin_sync;
    // Previous synchronised level for edge detection.
    logic [19:0] pin_prev;

    // Pins are asynchronous to clk, so they pass two flops first.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta <= 20'h00000;
            pin_sync <= 20'h00000;
            pin_prev <= 20'h00000;
        end else begin
            pin_meta <= {pd_in, pb_in, pa_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Synchronised levels split per port.
    wire [7:0] pa_sync = pin_sync[7:0];
    wire [6:0] pb_sync = pin_sync[14:8];
    wire [4:0] pd_sync = pin_sync[19:15];

    // Input lines show the pin, output lines the latch.
    wire [7:0] pa_view = (port_a_direction & pa_sync) |
        (~port_a_direction & port_a_data); // [RL3] [RL5]
    wire [6:0] pb_view = (port_b_direction_bits & pb_sync) |
        (~port_b_direction_bits & port_b_data_lines); // [RL3] [RL5]
    wire [4:0] pd_view = (port_d_direction_bits & pd_sync) |
        (~port_d_direction_bits & port_d_data_lines); // [RL3] [RL5]

    // Address decode, shared by read, write and bit paths.
    wire sel_pa = (mem_addr == `IOPW_ADDR_PORT_A);
    wire sel_pac = (mem_addr == `IOPW_ADDR_DIR_A);
    wire sel_pb = (mem_addr == `IOPW_ADDR_PORT_B);
    wire sel_pbc = (mem_addr == `IOPW_ADDR_DIR_B);
    wire sel_flags = (mem_addr == `IOPW_ADDR_FLAGS);
    wire sel_pd = (mem_addr == `IOPW_ADDR_PORT_D);
    wire sel_pdc = (mem_addr == `IOPW_ADDR_DIR_D);

    // Current value of the addressed register, zero if unmapped.
    wire [7:0] cur_val =
        sel_pa ? pa_view :
        sel_pac ? port_a_direction :
        sel_pb ? {1'b0, pb_view} :
        sel_pbc ? {1'b0, port_b_direction_bits} :
        sel_flags ? wake_edge_flags :
        sel_pd ? {3'b000, pd_view} :
        sel_pdc ? {3'b000, port_d_direction_bits} : 8'h00;

    // Replaces one bit of a byte; used for every port register.
    function automatic logic [7:0] put_bit(input logic [7:0] val,
                                           input logic [2:0] idx,
                                           input logic bv);
        logic [7:0] res;
        res = val;
        res[idx] = bv;
        return res;
    endfunction

    // Value stored by a byte write or a read-modify-write bit op.
    // The whole port is read, one bit changed, all bits written back.
    wire [7:0] bit_val = put_bit(cur_val, bit_idx, bit_set); // [RL7]
    wire [7:0] store_val = bit_op ? bit_val : mem_wdata;
    wire store = mem_wr | bit_op;

    // Latch and direction update. Latches change only on a store.
    always_ff @(posedge clk) begin
        if (rst) begin
            port_a_data <= `IOPW_RST_A; // [RL6]
            port_a_direction <= `IOPW_RST_A; // [RL6]
            port_b_data_lines <= `IOPW_RST_B; // [RL6]
            port_b_direction_bits <= `IOPW_RST_B; // [RL6]
            port_d_data_lines <= `IOPW_RST_D; // [RL6]
            port_d_direction_bits <= `IOPW_RST_D; // [RL6]
        end else if (store) begin
            // Only the addressed register takes the value. [RL4]
            if (sel_pa) port_a_data <= store_val;
            if (sel_pac) port_a_direction <= store_val; // [RL19]
            if (sel_pb) port_b_data_lines <= store_val[6:0];
            if (sel_pbc) port_b_direction_bits <= store_val[6:0]; // [RL19]
            if (sel_pd) port_d_data_lines <= store_val[4:0];
            if (sel_pdc) port_d_direction_bits <= store_val[4:0]; // [RL19]
        end
    end

    // Pin drive. A direction bit of one releases the pin. [RL1] [RL2]
    assign pa_out = port_a_data;
    assign pa_oe = ~port_a_direction;
    assign pb_out = port_b_data_lines;
    assign pb_oe = ~port_b_direction_bits;
    assign pd_out = port_d_data_lines;
    assign pd_oe = ~port_d_direction_bits;

    // Pull-ups only on lines set as inputs and enabled by option.
    assign pullup_en = pullup_opt & {port_d_direction_bits,
        port_b_direction_bits, port_a_direction}; // [RL8]

    // Read data is registered: one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_rdata <= 8'h00;
            mem_rvalid <= 1'b0;
        end else begin
            mem_rvalid <= mem_rd;
            if (mem_rd) mem_rdata <= cur_val; // [RL5] [RL20]
        end
    end

    // Edge detection on port A; other ports never wake. [RL10]
    wire [7:0] pa_prev = pin_prev[7:0];
    wire [7:0] pa_fall = pa_prev & ~pa_sync;
    wire [7:0] pa_rise = ~pa_prev & pa_sync;
    // Falling edges wake on any selected line. [RL11]
    wire [7:0] fall_wake = pa_fall & wake_sel;
    // Z lines also wake on rising edges when selected. [RL12]
    wire [1:0] z_rise = pa_rise[`IOPW_Z_HI:`IOPW_Z_LO] &
        wake_sel[`IOPW_Z_HI:`IOPW_Z_LO];
    // V lines wake on both edges only under their option. [RL13]
    wire [1:0] v_any = (pa_rise[`IOPW_V_HI:`IOPW_V_LO] |
        pa_fall[`IOPW_V_HI:`IOPW_V_LO]) & {2{v_wake_opt}};
    wire [1:0] z_any = z_rise | fall_wake[`IOPW_Z_HI:`IOPW_Z_LO];
    wire [1:0] v_hit = v_any | fall_wake[`IOPW_V_HI:`IOPW_V_LO];
    wire wake_evt = (pwr == IOPW_DOWN) &&
        ((|fall_wake) || (|z_any) || (|v_any));

    // Power state. Halt stops the clock; a wake event restarts it.
    iopw_pwr_t next_pwr;
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            IOPW_RUN: if (halt) next_pwr = IOPW_DOWN; // [RL9]
            IOPW_DOWN: if (wake_evt) next_pwr = IOPW_RUN; // [RL11]
            default: next_pwr = IOPW_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) pwr <= IOPW_RUN;
        else pwr <= next_pwr;
    end

    // The core clock gate follows the power state directly.
    assign sys_clk_run = (pwr == IOPW_RUN); // [RL9]

    // Flag set terms, raised only by a wake from power-down.
    wire down = (pwr == IOPW_DOWN);
    logic [7:0] flag_set;
    always_comb begin
        flag_set = 8'h00;
        flag_set[`IOPW_FLAG_V0] = down & v_hit[0]; // [RL14]
        flag_set[`IOPW_FLAG_V1] = down & v_hit[1]; // [RL14]
        flag_set[`IOPW_FLAG_Z0] = down & z_any[0]; // [RL15]
        flag_set[`IOPW_FLAG_Z1] = down & z_any[1]; // [RL15]
    end

    // Clear terms: a flag read clears all; a port A read clears Z.
    wire [7:0] flag_clr = (mem_rd & sel_flags) ? 8'hFF :
        (mem_rd & sel_pa) ? 8'hC0 : 8'h00; // [RL15] [RL16]

    // The read samples before the clear, and a set beats a clear,
    // so no wake event can slip through a coinciding read.
    always_ff @(posedge clk) begin
        if (rst) wake_edge_flags <= `IOPW_RST_FLAGS;
        else wake_edge_flags <= (wake_edge_flags & ~flag_clr) |
            flag_set; // [RL20]
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Halt while running: the clock is stopped one cycle later.
    sequence s_halted;
        (pwr == IOPW_RUN) && halt ##1 !sys_clk_run;
    endsequence

    a_reset_all_ones: assert property ( // [RL6]
        $past(rst) |-> (port_a_direction == 8'hFF) &&
        (pa_out == 8'hFF) && (pd_oe == 5'h00) && (pb_oe == 7'h00))
        else $error("Ports not all ones after reset.");

    a_output_enable: assert property ( // [RL2]
        (pa_oe == ~port_a_direction) && (pb_oe == ~port_b_direction_bits)
        && (pd_oe == ~port_d_direction_bits))
        else $error("Output enable does not follow direction.");

    a_output_reads_latch: assert property ( // [RL3]
        mem_rd && sel_pa && (port_a_direction == 8'h00) |=>
        mem_rvalid && (mem_rdata == $past(port_a_data)))
        else $error("Output read did not return latch.");

    a_input_reads_pin: assert property ( // [RL5]
        mem_rd && sel_pd && (port_d_direction_bits == 5'h1F) |=>
        (mem_rdata == {3'b000, $past(pd_sync)}))
        else $error("Input read did not return pin level.");

    a_latch_holds: assert property ( // [RL4]
        !mem_wr && !bit_op |=> $stable(pa_out) && $stable(pb_out)
        && $stable(pd_out))
        else $error("Output latch changed without a write.");

    a_bit_set_rmw: assert property ( // [RL7]
        bit_op && bit_set && sel_pa && (bit_idx == 3'h2) |=>
        pa_out[2] && (pa_out[1:0] == $past(pa_view[1:0])))
        else $error("Bit set lost read-modify-write data.");

    a_pullup_input: assert property ( // [RL8]
        (pullup_en & ~{pd_oe == 5'h00 ? 5'h1F : ~pd_oe,
        ~pb_oe, ~pa_oe}) == 20'h00000)
        else $error("Pull-up enabled on an output line.");

    a_halt_wake: assert property ( // [RL9] [RL11]
        s_halted ##0 (!sys_clk_run)[*2] ##0 pa_fall[0] && wake_sel[0]
        |=> sys_clk_run)
        else $error("Selected falling edge did not wake.");

    a_no_wake_other: assert property ( // [RL10]
        down && (pa_fall == 8'h00) && (pa_rise == 8'h00) |=> down)
        else $error("Wake without a port A edge.");

    a_z_rise_flag: assert property ( // [RL12] [RL15]
        down && pa_rise[`IOPW_Z_LO] && wake_sel[`IOPW_Z_LO] |=>
        sys_clk_run && wake_edge_flags[`IOPW_FLAG_Z0])
        else $error("Z rising edge did not wake and flag.");

    a_v_option_flag: assert property ( // [RL13] [RL14]
        down && v_wake_opt && pa_rise[`IOPW_V_HI] |=>
        wake_edge_flags[`IOPW_FLAG_V1] ##1 wake_edge_flags[`IOPW_FLAG_V1]
        || $past(mem_rd))
        else $error("V rising edge did not set its flag.");

    a_flag_read_clears: assert property ( // [RL20]
        mem_rd && sel_flags && (flag_set == 8'h00) |=>
        (wake_edge_flags == 8'h00) &&
        (mem_rdata == $past(wake_edge_flags)))
        else $error("Flag read did not return then clear.");

    a_pa_read_clears_z: assert property ( // [RL16]
        mem_rd && sel_pa && (flag_set == 8'h00) |=>
        (wake_edge_flags[7:6] == 2'b00) &&
        (wake_edge_flags[5:0] == $past(wake_edge_flags[5:0])))
        else $error("Port A read did not clear Z flags.");

endmodule // iopw_top

//--- dv/iopw_pins.sv
// Model of the switches and circuits wired to the twenty port pins.
`timescale 1ns/10ps
module iopw_pins (
    input wire logic [19:0] out_lvl, // Levels the device drives.
    input wire logic [19:0] oe, // High where the device drives.
    input wire logic [19:0] sw_lvl, // Levels the external switches hold.
    output logic [19:0] pin // Resolved pin levels.
);
    // A driving output overpowers the switch. The switch sits behind a
    // series resistor, so the device wins and no contention is modelled.
    // The timer line is plain I/O here: the timer stays on its internal
    // clock, so pin activity never reaches a counter.
    assign pin = (oe & out_lvl) | (~oe & sw_lvl);
endmodule // iopw_pins

//--- dv/test_io_port_wakeup.sv
// Self-checking bench for the I/O port with pin wake-up.
`timescale 1ns/10ps
`include "iopw_regs.svh"
module test_io_port_wakeup;
    logic clk = 0, rst = 1, mem_rd = 0, mem_wr = 0, bit_op = 0;
    logic bit_set = 0, halt = 0, v_wake_opt = 1, mem_rvalid, sys_clk_run;
    logic [7:0] mem_addr = 0, mem_wdata = 0, wake_sel = 8'h31, mem_rdata;
    logic [7:0] pa_in, pa_out, pa_oe;
    logic [6:0] pb_in, pb_out, pb_oe;
    logic [4:0] pd_in, pd_out, pd_oe;
    logic [2:0] bit_idx = 0;
    logic [19:0] pullup_opt = 20'hFFFFF, pullup_en, sw = 20'hFFFFF, pins;
    // Rows: dir addr, dir, data addr, data, switches, expected read.
    logic [63:0] rows [3] = '{64'h13_0F_12_3C_00FFC3_33,
        64'h15_55_14_AA_0F8FFF_2F, 64'h19_03_18_FF_00FFFF_1D};
    int failures = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    assign {pd_in, pb_in, pa_in} = pins;
    iopw_pins model (.out_lvl({pd_out, pb_out, pa_out}),
        .oe({pd_oe, pb_oe, pa_oe}), .sw_lvl(sw), .pin(pins));
    iopw_top dut (.clk(clk), .rst(rst), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .bit_op(bit_op), .bit_set(bit_set), .bit_idx(bit_idx),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .halt(halt),
        .sys_clk_run(sys_clk_run), .wake_sel(wake_sel),
        .v_wake_opt(v_wake_opt), .pullup_opt(pullup_opt),
        .pullup_en(pullup_en), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe));
    // Prints the counts and the verdict, then ends the run.
    task report_and_stop;
        $display("TB: checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Compares with case equality so an unknown never matches.
    task chk(input string n, input logic [19:0] e, input logic [19:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // All strobes rise at a falling edge and last one clock.
    task wr(input logic [7:0] a, input logic [7:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1;
        @(negedge clk);
        mem_wr = 0;
        // One idle cycle, so the next call never re-raises the strobe
        // in the same time step.
        @(negedge clk);
    endtask
    // The answer comes exactly one cycle after the read strobe.
    task rd(input logic [7:0] a, input logic [7:0] e);
        mem_addr = a;
        mem_rd = 1;
        @(negedge clk);
        mem_rd = 0;
        chk("read valid", 1, mem_rvalid);
        chk($sformatf("read of %h", a), e, mem_rdata);
        @(negedge clk);
    endtask
    task bop(input logic [7:0] a, input logic [2:0] i, input logic s);
        mem_addr = a;
        bit_idx = i;
        bit_set = s;
        bit_op = 1;
        @(negedge clk);
        bit_op = 0;
        @(negedge clk);
    endtask
    task halt_down;
        halt = 1;
        @(negedge clk);
        halt = 0;
        chk("run after halt", 0, sys_clk_run);
    endtask
    // Wake takes a few cycles through the pin synchronisers; bounded.
    task wait_run;
        int i;
        for (i = 0; i < 12 && sys_clk_run !== 1'b1; i++) @(negedge clk);
        if (sys_clk_run !== 1'b1) begin
            failures++;
            $display("CHECK FAILED wake expected 1 seen %b", sys_clk_run);
            report_and_stop;
        end
    endtask
    // Cuts a hang short well inside the cycle budget.
    initial begin
        #100000;
        failures++;
        $display("CHECK FAILED run time expected end seen limit");
        report_and_stop;
    end
    initial begin
        cyc(3);
        rst = 0;
        rd(`IOPW_ADDR_DIR_A, 8'hFF);
        rd(`IOPW_ADDR_DIR_B, 8'h7F);
        rd(`IOPW_ADDR_DIR_D, 8'h1F);
        rd(`IOPW_ADDR_FLAGS, 8'h00);
        chk("pa out", 8'hFF, pa_out);
        chk("pa oe", 8'h00, pa_oe);
        rd(8'h17, 8'h00);
        $display("TB: reset test done");
        // Direction is set before data, as software is told to do.
        foreach (rows[r]) begin
            wr(rows[r][63:56], rows[r][55:48]);
            wr(rows[r][47:40], rows[r][39:32]);
            sw = rows[r][27:8];
            cyc(3);
            rd(rows[r][47:40], rows[r][7:0]);
            rd(rows[r][63:56], rows[r][55:48]);
        end
        chk("pa latch", 8'h3C, pa_out);
        chk("pa oe", 8'hF0, pa_oe);
        chk("pull-ups", 20'h1D50F, pullup_en);
        chk("pb out", 7'h2A, pb_out);
        chk("pb oe", 7'h2A, pb_oe);
        chk("pd out", 5'h1F, pd_out);
        chk("pd oe", 5'h1C, pd_oe);
        $display("TB: port table done");
        bop(`IOPW_ADDR_DIR_A, 3'h7, 1'b1);
        rd(`IOPW_ADDR_DIR_A, 8'h8F);
        sw = 20'hFFFC3;
        cyc(3);
        // Input bits take the pin level into the latch on the rewrite.
        bop(`IOPW_ADDR_PORT_A, 3'h4, 1'b0);
        chk("pa after bit op", 8'hA3, pa_out);
        rd(`IOPW_ADDR_PORT_A, 8'hA3);
        $display("TB: bit op test done");
        wr(`IOPW_ADDR_DIR_A, 8'hFF);
        sw = 20'hFFFEF;
        cyc(4);
        halt_down;
        sw = 20'hFFEEF;
        cyc(8);
        chk("run after port b edge", 0, sys_clk_run);
        sw = 20'hFFEFF;
        wait_run;
        rd(`IOPW_ADDR_FLAGS, 8'h40);
        rd(`IOPW_ADDR_FLAGS, 8'h00);
        halt_down;
        sw = 20'hFFE7F;
        wait_run;
        rd(`IOPW_ADDR_FLAGS, 8'h02);
        rd(`IOPW_ADDR_FLAGS, 8'h00);
        sw = 20'hFFEFF;
        cyc(4);
        halt_down;
        sw = 20'hFFEDF;
        wait_run;
        rd(`IOPW_ADDR_PORT_A, 8'hDF);
        rd(`IOPW_ADDR_FLAGS, 8'h00);
        sw = 20'hFFEFF;
        cyc(4);
        halt_down;
        sw = 20'hFFEFE;
        wait_run;
        rd(`IOPW_ADDR_FLAGS, 8'h00);
        $display("TB: wake test done");
        report_and_stop;
    end
endmodule // test_io_port_wakeup
